// ==== hw/key_switch_controller.sv ====
`timescale 1ns/10ps
module key_switch_controller import key_switch_pkg::*; #(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire axil_req_s bus_req,
  output axil_rsp_s bus_rsp,
  input wire logic power_button,
  input wire logic reset_button,
  input wire logic nmi_button,
  input wire logic [4:0] cursor_switch,
  input wire logic second_switch,
  input wire logic third_switch,
  output logic system_power,
  output logic nmi_request,
  output logic key_irq
);
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ctrl;
    logic [7:0] interval;
    logic [3:0] flags;
    logic summary;
    logic irq;
    logic [15:0] pattern;
    logic [APP_KEYS-1:0] held;
    logic [5:0] rep_cnt;
    power_e power;
    logic armed;
    logic [7:0] hold;
    logic nmi_prev;
    logic nmi_pulse;
  } ctl_s;

  ctl_s s;
  ctl_s next_s;
  logic tick;
  logic changed;
  logic [APP_KEYS-1:0] stable;
  logic ev_on;
  logic ev_off;
  logic ev_rep;
  logic ev_pwr;
  logic do_write;
  logic wr_lo;
  logic [7:0] wr_idx;
  logic [3:0] keep_flags;
  logic keep_summary;

  // Periodic sampling and three-sample debounce of the display board
  switch_sampler #(
    .SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)
  ) u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .raw({third_switch, second_switch, cursor_switch}),
    .sample_tick(tick),
    .stable(stable),
    .changed(changed)
  );

  // Auto-repeat length in sample ticks; an empty register falls back
  // to the base period so a careless write cannot stop repeats
  function automatic logic [5:0] repeat_ticks(input logic [7:0] sel);
    logic [5:0] t;
    logic found;
    t = 6'(REPEAT_BASE_TICKS);
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (sel[i] && !found) begin
        t = 6'(REPEAT_BASE_TICKS + REPEAT_STEP_TICKS * i);
        found = 1'b1;
      end
    end
    return t;
  endfunction : repeat_ticks

  // Debounced vector to pattern layout
  function automatic logic [15:0] to_pattern(input logic [6:0] v);
    logic [15:0] p;
    p = KEY_PATTERN_RST;
    p[PAT_CURSOR_LSB +: 5] = v[4:0];
    p[PAT_SECOND_SWITCH] = v[5];
    p[PAT_THIRD_SWITCH] = v[6];
    return p;
  endfunction : to_pattern

  // Read data; unmapped bits and the other summary sources read zero
  function automatic logic [31:0] read_reg(input logic [7:0] idx,
                                           input ctl_s c);
    logic [31:0] d;
    d = '0;
    case (idx)
      IDX_KEY_CONTROL: d = {26'h0, c.ctrl};
      IDX_KEY_REPEAT_INTERVAL: d = {24'h0, c.interval};
      IDX_KEY_EVENT_STATUS: d = {27'h0, c.flags, 1'b0};
      IDX_KEY_PATTERN: d = {16'h0, c.pattern};
      IDX_SYSTEM_EVENT_SUMMARY: d = {29'h0, c.summary, 2'h0};
      default: d = '0;
    endcase
    return d;
  endfunction : read_reg

  function automatic logic mapped(input logic [7:0] idx);
    return (idx == IDX_KEY_CONTROL) || (idx == IDX_KEY_REPEAT_INTERVAL) ||
           (idx == IDX_KEY_EVENT_STATUS) || (idx == IDX_KEY_PATTERN) ||
           (idx == IDX_SYSTEM_EVENT_SUMMARY);
  endfunction : mapped

  // All next-state logic
  always_comb begin
    next_s = s;
    ev_on = 1'b0;
    ev_off = 1'b0;
    ev_rep = 1'b0;
    ev_pwr = 1'b0;
    next_s.nmi_pulse = 1'b0;

    // Application keys are only tracked while input is enabled
    if (s.ctrl[APP_INPUT_ENABLE]) begin
      if (changed) begin
        next_s.held = stable;
        next_s.rep_cnt = '0;
        // Full release keeps the last pressed pattern visible
        if (stable != '0) begin
          next_s.pattern = to_pattern(stable);
        end
        if ((stable & ~s.held) != '0) begin
          ev_on = 1'b1;
        end
        if ((stable == '0) && (s.held != '0)) begin
          ev_off = 1'b1;
        end
      end else if (tick && (s.held != '0)) begin
        if (s.rep_cnt == repeat_ticks(s.interval) - 6'd1) begin
          ev_rep = 1'b1;
          next_s.rep_cnt = '0;
        end else begin
          next_s.rep_cnt = s.rep_cnt + 6'd1;
        end
      end
    end

    // Power button is timed in sample ticks; armed blocks a second
    // transition until the button has been let go
    if (tick) begin
      if (!power_button) begin
        next_s.hold = '0;
        next_s.armed = 1'b1;
      end else if (s.hold != 8'hff) begin
        next_s.hold = s.hold + 8'd1;
      end
      if (power_button && s.armed) begin
        case (s.power)
          PWR_OFF: begin
            if (s.hold == 8'(POWER_ON_TICKS - 1)) begin
              next_s.power = PWR_ON;
              next_s.armed = 1'b0;
            end
          end
          PWR_ON: begin
            if (s.hold == 8'(POWER_OFF_TICKS - 1)) begin
              next_s.power = PWR_OFF;
              next_s.armed = 1'b0;
            end
          end
          default: next_s.power = PWR_OFF;
        endcase
      end
      if (power_button && (s.hold == 8'(POWER_OFF_TICKS - 1))) begin
        ev_pwr = 1'b1;
      end
    end
    // Reset button overrides the power button and forces power off
    if (reset_button) begin
      next_s.power = PWR_OFF;
    end

    // NMI on the press edge, only while the gate is open
    next_s.nmi_prev = nmi_button;
    if (nmi_button && !s.nmi_prev && s.ctrl[NONMASKABLE_GATE]) begin
      next_s.nmi_pulse = 1'b1;
    end

    // Write address and data are taken independently
    if (bus_req.awvalid && !s.aw_held && !s.bvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = bus_req.awaddr;
    end
    if (bus_req.wvalid && !s.w_held && !s.bvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = bus_req.wdata;
      next_s.w_strb = bus_req.wstrb;
    end
    if (s.bvalid && bus_req.bready) begin
      next_s.bvalid = 1'b0;
    end

    do_write = s.aw_held && s.w_held && !s.bvalid;
    wr_idx = s.aw_addr[ADDR_W-1:2];
    wr_lo = do_write && s.w_strb[0];
    keep_flags = 4'hf;
    keep_summary = 1'b1;
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    // Pattern writes are accepted and ignored
    if (wr_lo) begin
      case (wr_idx)
        IDX_KEY_CONTROL: next_s.ctrl = s.w_data[5:0];
        IDX_KEY_REPEAT_INTERVAL: next_s.interval = s.w_data[7:0];
        IDX_KEY_EVENT_STATUS: keep_flags = s.w_data[FLAG_LSB +: 4];
        IDX_SYSTEM_EVENT_SUMMARY: begin
          keep_summary = s.w_data[KEYS_SUMMARY_FLAG];
        end
        default: keep_flags = 4'hf;
      endcase
    end

    // A fresh event wins over a clear in the same cycle
    next_s.flags[PRESS_FLAG] = ev_on | (s.flags[PRESS_FLAG] &
                               keep_flags[PRESS_FLAG]);
    next_s.flags[RELEASE_FLAG] = ev_off | (s.flags[RELEASE_FLAG] &
                                 keep_flags[RELEASE_FLAG]);
    next_s.flags[REPEAT_FLAG] = ev_rep | (s.flags[REPEAT_FLAG] &
                                keep_flags[REPEAT_FLAG]);
    next_s.flags[POWER_BUTTON_FLAG] = ev_pwr |
      (s.flags[POWER_BUTTON_FLAG] & keep_flags[POWER_BUTTON_FLAG]);
    next_s.summary = (|next_s.flags) | (s.summary & keep_summary);
    next_s.irq = |(next_s.flags & next_s.ctrl[4:1]);

    // Read channel; one read outstanding
    if (s.rvalid && bus_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (bus_req.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_reg(bus_req.araddr[ADDR_W-1:2], s);
      next_s.rresp = mapped(bus_req.araddr[ADDR_W-1:2]) ? RESP_OKAY :
                     RESP_SLVERR;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= KEY_CONTROL_RST;
      s.interval <= KEY_REPEAT_INTERVAL_RST;
      s.pattern <= KEY_PATTERN_RST;
      s.power <= PWR_OFF;
      s.armed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Ready terms come straight from state, never from the request
  assign bus_rsp.awready = !s.aw_held && !s.bvalid;
  assign bus_rsp.wready = !s.w_held && !s.bvalid;
  assign bus_rsp.bvalid = s.bvalid;
  assign bus_rsp.bresp = s.bresp;
  assign bus_rsp.arready = !s.rvalid;
  assign bus_rsp.rvalid = s.rvalid;
  assign bus_rsp.rdata = s.rdata;
  assign bus_rsp.rresp = s.rresp;
  assign system_power = (s.power == PWR_ON);
  assign nmi_request = s.nmi_pulse;
  assign key_irq = s.irq;

  ctrl_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_req.arvalid && !s.rvalid &&
     bus_req.araddr[ADDR_W-1:2] == IDX_KEY_CONTROL)
    |=> s.rvalid && (s.rdata[31:6] == '0))
    else $error("control read showed nonzero upper bits");

  reset_power_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    reset_button |=> !system_power)
    else $error("power stayed on after reset button");

  power_on_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(system_power) |-> $past(power_button) &&
    ($past(s.hold) == 8'(POWER_ON_TICKS - 1)))
    else $error("power turned on without half-second hold");

  power_off_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(system_power) && !$past(reset_button)) |->
    ($past(s.hold) == 8'(POWER_OFF_TICKS - 1)))
    else $error("power turned off without two-second hold");

  nmi_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_request |-> $past(s.ctrl[NONMASKABLE_GATE]) && $past(nmi_button)
    ##1 !nmi_request)
    else $error("nmi request without gate or press");

  pattern_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !s.ctrl[APP_INPUT_ENABLE] |=> $stable(s.pattern) && !s.flags[0] ||
    $past(s.flags[0]))
    else $error("pattern or key-on moved while input disabled");

  press_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_on |=> s.flags[PRESS_FLAG] && s.summary)
    else $error("key-on event lost");

  repeat_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_rep |-> (tick && (s.held != '0) && s.ctrl[APP_INPUT_ENABLE])
    ##1 s.flags[REPEAT_FLAG])
    else $error("repeat event without a held key");

  // Full release must leave the last pressed layout visible
  release_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_off |=> $stable(s.pattern) && s.flags[RELEASE_FLAG] && (s.held == '0))
    else $error("full release lost its event or pattern");

  power_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_pwr |-> tick && power_button ##1 s.flags[POWER_BUTTON_FLAG])
    else $error("power button flag not set after long hold");

  press_pattern_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_on |=> (s.pattern == to_pattern($past(stable))))
    else $error("pattern does not match debounced press");

  summary_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|s.flags) |-> s.summary)
    else $error("summary bit clear while a key flag is set");

  irq_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    key_irq |-> $past(ev_on || ev_off || ev_rep || ev_pwr) ||
    $past(key_irq) || $past(do_write))
    else $error("interrupt raised without a cause");
endmodule : key_switch_controller

// ==== common/key_switch_pkg.sv ====
package key_switch_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_PERIOD_MS = 10;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DEBOUNCE_SAMPLES = 3;
  localparam int POWER_ON_HOLD_MS = 500;
  localparam int POWER_OFF_HOLD_MS = 2000;
  localparam int REPEAT_BASE_MS = 100;
  localparam int REPEAT_STEP_MS = 50;
  localparam int POWER_ON_TICKS = POWER_ON_HOLD_MS / SAMPLE_PERIOD_MS;
  localparam int POWER_OFF_TICKS = POWER_OFF_HOLD_MS / SAMPLE_PERIOD_MS;
  localparam int REPEAT_BASE_TICKS = REPEAT_BASE_MS / SAMPLE_PERIOD_MS;
  localparam int REPEAT_STEP_TICKS = REPEAT_STEP_MS / SAMPLE_PERIOD_MS;
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_KEY_CONTROL = 8'h60;
  localparam logic [7:0] IDX_KEY_REPEAT_INTERVAL = 8'h61;
  localparam logic [7:0] IDX_KEY_EVENT_STATUS = 8'h62;
  localparam logic [7:0] IDX_KEY_PATTERN = 8'h64;
  localparam logic [7:0] IDX_SYSTEM_EVENT_SUMMARY = 8'h90;
  // Reset values
  localparam logic [5:0] KEY_CONTROL_RST = 6'h20;
  localparam logic [7:0] KEY_REPEAT_INTERVAL_RST = 8'h01;
  localparam logic [15:0] KEY_PATTERN_RST = 16'h0000;
  // Control fields
  localparam int APP_INPUT_ENABLE = 0;
  localparam int NONMASKABLE_GATE = 5;
  // Status fields, stored as flags[3:0] for bits 4:1
  localparam int FLAG_LSB = 1;
  localparam int PRESS_FLAG = 0;
  localparam int RELEASE_FLAG = 1;
  localparam int REPEAT_FLAG = 2;
  localparam int POWER_BUTTON_FLAG = 3;
  localparam int KEYS_SUMMARY_FLAG = 2;
  // Pattern fields
  localparam int PAT_CURSOR_LSB = 0;
  localparam int PAT_SECOND_SWITCH = 10;
  localparam int PAT_THIRD_SWITCH = 8;
  localparam int APP_KEYS = 7;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PWR_OFF = 1'b0,
    PWR_ON = 1'b1
  } power_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
endpackage : key_switch_pkg

// ==== hw/switch_sampler.sv ====
`timescale 1ns/10ps
module switch_sampler import key_switch_pkg::*; #(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [APP_KEYS-1:0] raw,
  output logic sample_tick,
  output logic [APP_KEYS-1:0] stable,
  output logic changed
);
  localparam int CW = $clog2(SAMPLE_CYCLES_P + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
    logic [APP_KEYS-1:0] h0;
    logic [APP_KEYS-1:0] h1;
    logic [APP_KEYS-1:0] h2;
    logic [APP_KEYS-1:0] stable;
    logic changed;
  } sampler_s;

  sampler_s s;
  sampler_s next_s;
  logic [APP_KEYS-1:0] agree;

  // Each key agrees when its last three samples match
  for (genvar i = 0; i < APP_KEYS; i++) begin : g_agree
    assign agree[i] = (s.h0[i] == s.h1[i]) && (s.h1[i] == s.h2[i]);
  end

  // Sample history shifts once per period; the whole vector must agree
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.changed = 1'b0;
    if (s.cnt == CW'(SAMPLE_CYCLES_P - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
      next_s.h2 = s.h1;
      next_s.h1 = s.h0;
      next_s.h0 = raw;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
    if (s.tick && (&agree) && (s.h0 != s.stable)) begin
      next_s.stable = s.h0;
      next_s.changed = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sample_tick = s.tick;
  assign stable = s.stable;
  assign changed = s.changed;

  sample_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    s.tick |=> !s.tick)
    else $error("sample tick repeated on consecutive cycles");

  debounce_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
    s.changed |-> (s.stable == s.h0) && (s.h0 == s.h1) && (s.h1 == s.h2))
    else $error("stable vector changed without three equal samples");
endmodule : switch_sampler

// ==== verification/switch_board_model.sv ====
`timescale 1ns/10ps
module switch_board_model (
  input wire logic clk,
  input wire logic [6:0] keys,
  input wire logic bounce,
  output logic [4:0] cursor_switch,
  output logic second_switch,
  output logic third_switch
);
  logic [6:0] level = 7'h00;
  logic [6:0] last = 7'h00;
  int chatter = 0;
  // Contacts chatter for three clocks after a change. That is shorter than
  // one sample period, so only the three-sample filter can hide it.
  always @(posedge clk) begin
    if (keys != last && bounce)
      chatter <= 3;
    else if (chatter > 0)
      chatter <= chatter - 1;
    last <= keys;
    level <= (chatter > 0) ? 7'($urandom) : keys;
  end
  // Board wiring: bits 4:0 cursor, bit 5 second, bit 6 third
  assign cursor_switch = level[4:0];
  assign second_switch = level[5];
  assign third_switch = level[6];
endmodule : switch_board_model

// ==== verification/key_switch_controller_tb.sv ====
`timescale 1ns/10ps
module key_switch_controller_tb import key_switch_pkg::*;;
  localparam int SC = 4;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic power_button = 1'b0;
  logic reset_button = 1'b0;
  logic nmi_button = 1'b0;
  logic [6:0] keys = 7'h00;
  logic bounce = 1'b1;
  logic [4:0] cursor;
  logic sw2;
  logic sw3;
  logic system_power;
  logic nmi_request;
  logic key_irq;
  logic irq_d = 1'b0;
  logic [1:0] bresp_seen;
  logic [33:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int nmi_cnt = 0;
  int rise_t = 0;

  always #50 clk = ~clk;

  // Short sample period keeps hold and repeat times affordable
  key_switch_controller #(.SAMPLE_CYCLES_P(SC)) dut (.clk(clk),
    .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp),
    .power_button(power_button), .reset_button(reset_button),
    .nmi_button(nmi_button), .cursor_switch(cursor),
    .second_switch(sw2), .third_switch(sw3),
    .system_power(system_power), .nmi_request(nmi_request),
    .key_irq(key_irq));

  switch_board_model board (.clk(clk), .keys(keys), .bounce(bounce),
    .cursor_switch(cursor), .second_switch(sw2), .third_switch(sw3));

  task automatic check(input string name, input logic [33:0] seen,
                       input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Read answers are matched in order against the driver's notes; the
  // monitor also times interrupt edges and counts NMI pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_d <= key_irq;
    if (key_irq === 1'b1 && irq_d === 1'b0)
      rise_t <= cyc;
    if (nmi_request === 1'b1)
      nmi_cnt <= nmi_cnt + 1;
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected read", 34'h1, 34'h0);
      else
        check("read", {rsp.rresp, rsp.rdata}, exp_q.pop_front());
    end
    if (cyc == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    // Ready stays high between writes so back-to-back calls never
    // drive it twice in one time step
    bresp_seen = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] resp);
    exp_q.push_back({resp, d});
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    // Ready stays high, so the next read may start right away
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
  endtask : rd

  task automatic nmi_press();
    nmi_button <= 1'b1;
    wait_clk(5);
    nmi_button <= 1'b0;
    wait_clk(3);
  endtask : nmi_press

  task automatic hold_power(input int ticks);
    power_button <= 1'b1;
    wait_clk(ticks * SC);
    power_button <= 1'b0;
    wait_clk(3 * SC);
  endtask : hold_power

  task automatic wait_rise();
    int lo;
    lo = rise_t;
    repeat (1000) if (rise_t == lo) @(posedge clk);
  endtask : wait_rise

  function automatic logic [31:0] pat_of(input logic [6:0] k);
    return {21'h0, k[5], 1'b0, k[6], 3'h0, k[4:0]};
  endfunction : pat_of

  initial begin
    logic [7:0] iv;
    logic [6:0] k;
    int lo;
    int t1;
    void'($urandom(32'h9d00d293));
    wait_clk(10);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_KEY_CONTROL, 32'h20, RESP_OKAY);
    rd(IDX_KEY_REPEAT_INTERVAL, 32'h01, RESP_OKAY);
    rd(IDX_KEY_EVENT_STATUS, 32'h0, RESP_OKAY);
    rd(IDX_SYSTEM_EVENT_SUMMARY, 32'h0, RESP_OKAY);
    rd(8'h63, 32'h0, RESP_SLVERR);
    wr(8'h70, 32'h5);
    check("unmapped bresp", bresp_seen, RESP_SLVERR);
    wr(IDX_KEY_CONTROL, 32'hff);
    check("control bresp", bresp_seen, RESP_OKAY);
    rd(IDX_KEY_CONTROL, 32'h3f, RESP_OKAY);
    wr(IDX_KEY_PATTERN, 32'hffff);
    rd(IDX_KEY_PATTERN, 32'h0, RESP_OKAY);
    $display("test registers done");
    t1 = nmi_cnt;
    nmi_press();
    check("nmi gated on", nmi_cnt - t1, 1);
    wr(IDX_KEY_CONTROL, 32'h1f);
    nmi_press();
    check("nmi gated off", nmi_cnt - t1, 1);
    $display("test nmi done");
    wr(IDX_KEY_CONTROL, 32'h1e);
    keys <= 7'h7f;
    wait_clk(10 * SC);
    rd(IDX_KEY_PATTERN, 32'h0, RESP_OKAY);
    rd(IDX_KEY_EVENT_STATUS, 32'h0, RESP_OKAY);
    check("irq while disabled", key_irq, 1'b0);
    keys <= 7'h00;
    wait_clk(6 * SC);
    $display("test input disabled done");
    wr(IDX_KEY_REPEAT_INTERVAL, 32'h80);
    wr(IDX_KEY_CONTROL, 32'h23);
    k = 7'($urandom) | 7'h01;
    keys <= k;
    wait_clk(6);
    check("irq before debounce", key_irq, 1'b0);
    wait_clk(4 * SC);
    check("press irq", key_irq, 1'b1);
    rd(IDX_KEY_PATTERN, pat_of(k), RESP_OKAY);
    rd(IDX_KEY_EVENT_STATUS, 32'h02, RESP_OKAY);
    rd(IDX_SYSTEM_EVENT_SUMMARY, 32'h04, RESP_OKAY);
    wr(IDX_KEY_EVENT_STATUS, 32'h0);
    rd(IDX_KEY_EVENT_STATUS, 32'h0, RESP_OKAY);
    check("irq after clear", key_irq, 1'b0);
    wr(IDX_SYSTEM_EVENT_SUMMARY, 32'h0);
    rd(IDX_SYSTEM_EVENT_SUMMARY, 32'h0, RESP_OKAY);
    keys <= 7'h00;
    wait_clk(5 * SC);
    rd(IDX_KEY_PATTERN, pat_of(k), RESP_OKAY);
    rd(IDX_KEY_EVENT_STATUS, 32'h04, RESP_OKAY);
    check("release irq masked", key_irq, 1'b0);
    wr(IDX_KEY_CONTROL, 32'h27);
    wait_clk(2);
    check("release irq", key_irq, 1'b1);
    wr(IDX_KEY_EVENT_STATUS, 32'h0);
    $display("test press release done");
    // Several bits set on purpose: the lowest one sets the period
    iv = (8'($urandom) & 8'hf8) | 8'h04;
    lo = 0;
    for (int b = 7; b >= 0; b--) if (iv[b]) lo = b;
    wr(IDX_KEY_REPEAT_INTERVAL, {24'h0, iv});
    rd(IDX_KEY_REPEAT_INTERVAL, {24'h0, iv}, RESP_OKAY);
    wr(IDX_KEY_CONTROL, 32'h29);
    keys <= 7'h10;
    wait_clk(5 * SC);
    wr(IDX_KEY_EVENT_STATUS, 32'h0);
    wait_rise();
    t1 = rise_t;
    wr(IDX_KEY_EVENT_STATUS, 32'h0);
    wait_rise();
    check("repeat period", rise_t - t1,
          (REPEAT_BASE_TICKS + REPEAT_STEP_TICKS * lo) * SC);
    check("repeat irq", key_irq, 1'b1);
    keys <= 7'h00;
    wait_clk(5 * SC);
    $display("test repeat done");
    wr(IDX_KEY_CONTROL, 32'h31);
    wr(IDX_KEY_EVENT_STATUS, 32'h0);
    hold_power(45);
    check("power short hold", system_power, 1'b0);
    hold_power(55);
    check("power on", system_power, 1'b1);
    hold_power(100);
    check("power kept", system_power, 1'b1);
    check("no power flag", key_irq, 1'b0);
    hold_power(210);
    check("power off", system_power, 1'b0);
    check("power irq", key_irq, 1'b1);
    rd(IDX_KEY_EVENT_STATUS, 32'h10, RESP_OKAY);
    hold_power(55);
    check("power on again", system_power, 1'b1);
    reset_button <= 1'b1;
    wait_clk(2);
    check("reset button", system_power, 1'b0);
    reset_button <= 1'b0;
    $display("test power done");
    report_and_stop();
  end
endmodule : key_switch_controller_tb
